// >>> include/brm_pkg.sv
// Constants, types and helpers for the buck rail mode control block
package brm_pkg;

  // Register addresses (7-bit address space of the serial port)
  localparam logic [6:0] BRM_ADDR_1V5_CTL  = 7'h39;
  localparam logic [6:0] BRM_ADDR_CORE_CTL = 7'h3C;
  localparam logic [6:0] BRM_ADDR_CUR_1V5H = 7'h70;
  localparam logic [6:0] BRM_ADDR_CUR_1V5L = 7'h71;
  localparam logic [6:0] BRM_ADDR_CUR_CORH = 7'h72;
  localparam logic [6:0] BRM_ADDR_CUR_CORL = 7'h73;
  localparam logic [6:0] BRM_ADDR_STATUS   = 7'h74;
  localparam logic [6:0] BRM_ADDR_TRIM     = 7'h75;

  // Reset values
  localparam logic [7:0] BRM_RST_1V5_CTL  = 8'h07;
  localparam logic [7:0] BRM_RST_CORE_CTL = 8'h24;

  // Field positions inside a rail control register
  localparam int BRM_STATE_LSB = 0;
  localparam int BRM_EXIT_LSB  = 3;
  localparam int BRM_VSEL_LSB  = 6;
  localparam int BRM_VALID_BIT = 2;

  // Status register bit positions
  localparam int BRM_STS_FLT_1V5  = 0;
  localparam int BRM_STS_FLT_CORE = 1;
  localparam int BRM_STS_HIGH_V   = 2;
  localparam int BRM_STS_GPS      = 3;

  // State codes; codes below 4 are reserved or mean do not copy
  localparam logic [2:0] BRM_ST_OFF = 3'h4;
  localparam logic [2:0] BRM_ST_PFM = 3'h5;
  localparam logic [2:0] BRM_ST_APS = 3'h6;
  localparam logic [2:0] BRM_ST_PWM = 3'h7;

  // Voltage select codes
  localparam logic [1:0] BRM_VSEL_LOW  = 2'h0;
  localparam logic [1:0] BRM_VSEL_HIGH = 2'h1;

  // Core voltage code: volts = 0.6 + code * 0.025
  localparam logic [4:0] BRM_VC_1V25   = 5'h1A;
  localparam logic [4:0] BRM_VC_3G_DEF = 5'h10;

  // Serial frame: command byte then data byte, MSB first
  localparam logic [4:0] BRM_SPI_CMD_BITS   = 5'h08;
  localparam logic [4:0] BRM_SPI_FRAME_BITS = 5'h10;

  typedef enum logic [3:0] {
    BRM_MODE_OFF = 4'b0001,
    BRM_MODE_PFM = 4'b0010,
    BRM_MODE_APS = 4'b0100,
    BRM_MODE_PWM = 4'b1000
  } brm_mode_t;

  // Map a valid state code to its mode
  function automatic brm_mode_t brm_decode(input logic [2:0] code);
    brm_mode_t m;
    m = BRM_MODE_OFF;
    unique case (code)
      BRM_ST_PFM: m = BRM_MODE_PFM;
      BRM_ST_APS: m = BRM_MODE_APS;
      BRM_ST_PWM: m = BRM_MODE_PWM;
      default:    m = BRM_MODE_OFF;
    endcase
    return m;
  endfunction

endpackage

// >>> verification/brm_host_model.sv
// Host serial controller model driving the register port
`timescale 1ns/1ps
module brm_host_model (
  // Clock
  input  wire logic  mclk,
  // Serial pins
  output logic       sclk,
  output logic       cs_n,
  output logic       mosi,
  input  wire logic  miso,
  // Read result
  output logic       rd_done,
  output logic [7:0] rd_byte
);
  logic tgl = 1'b0;
  logic dbit = 1'b0;
  // Deselected data line wanders so a stale bit is never taken
  assign mosi = cs_n ? tgl : dbit;
  always @(negedge mclk) tgl <= ~tgl;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end
  // One 16-bit frame; each sclk phase held 4 mclk
  task automatic xfer(input logic [15:0] f);
    @(negedge mclk);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      dbit = f[i];
      repeat (4) @(negedge mclk);
      if (i < 8) rd_byte = {rd_byte[6:0], miso};
      sclk = 1'b1;
      repeat (4) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge mclk);
    cs_n = 1'b1;
    rd_done = !f[15];
    @(negedge mclk);
    rd_done = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
endmodule

// >>> verification/brm_props.sv
// Port checks for the buck rail mode control block
`timescale 1ns/1ps
module brm_props
  import brm_pkg::*;
(
  // Clock and reset
  input wire logic      mclk,
  input wire logic      arst_n,
  // Observed ports
  input wire logic      spi_cs_n,
  input wire logic      spi_miso,
  input wire logic      spi_miso_oe,
  input wire logic      gps_supply_rail_1v3,
  input wire logic      oc_1v5_detect,
  input wire logic      oc_core_detect,
  input wire brm_mode_t buck_1v5_rail_mode,
  input wire logic      buck_1v5_rail_high_v,
  input wire logic      buck_1v5_rail_discharge,
  input wire logic      buck_1v5_rail_fault,
  input wire brm_mode_t comms_core_rail_mode,
  input wire logic      comms_core_rail_discharge,
  input wire logic      comms_core_overcurrent_flag,
  input wire logic      regulator_fault_interrupt
);
  // Outputs hold reset values until the synchronised release lands
  logic [1:0] up_r;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  default clocking @(posedge mclk); endclocking
  default disable iff (up_r != 2'h3);

  irq_follow_a: assert property (
    regulator_fault_interrupt == $past(oc_1v5_detect | oc_core_detect))
    else $error("fault interrupt not OR of detects");
  fault_1v5_a: assert property (
    buck_1v5_rail_fault == $past(oc_1v5_detect))
    else $error("1v5 fault flag wrong");
  fault_core_a: assert property (
    comms_core_overcurrent_flag == $past(oc_core_detect))
    else $error("core fault flag wrong");
  dis_1v5_a: assert property (
    buck_1v5_rail_discharge == (buck_1v5_rail_mode == BRM_MODE_OFF))
    else $error("1v5 discharge not tied to off");
  dis_core_a: assert property (
    comms_core_rail_discharge == (comms_core_rail_mode == BRM_MODE_OFF))
    else $error("core discharge not tied to off");
  gps_raise_a: assert property (
    gps_supply_rail_1v3 |=> buck_1v5_rail_high_v)
    else $error("1v5 rail not raised for gps");
  mode_onehot_a: assert property (
    $onehot(buck_1v5_rail_mode) && $onehot(comms_core_rail_mode))
    else $error("mode outputs not one-hot");
  miso_oe_a: assert property (
    spi_miso_oe == !$past(spi_cs_n))
    else $error("miso enable not following select");
  miso_idle_a: assert property (
    spi_cs_n |=> !spi_miso)
    else $error("miso driven while deselected");
endmodule
bind brm_rail_ctrl brm_props chk (.mclk, .arst_n, .spi_cs_n, .spi_miso, .spi_miso_oe,
  .gps_supply_rail_1v3, .oc_1v5_detect, .oc_core_detect, .buck_1v5_rail_mode,
  .buck_1v5_rail_high_v, .buck_1v5_rail_discharge, .buck_1v5_rail_fault,
  .comms_core_rail_mode, .comms_core_rail_discharge, .comms_core_overcurrent_flag,
  .regulator_fault_interrupt);

// >>> verification/buck_rail_mode_control_tb.sv
// Self-checking bench for the buck rail mode control block
`timescale 1ns/1ps
module buck_rail_mode_control_tb import brm_pkg::*; ();
  logic mclk = 1'b0, arst_n = 1'b0, stby = 1'b0, gps = 1'b0, tvalid = 1'b0;
  logic oc1 = 1'b0, oc2 = 1'b0, avalid = 1'b0, asel = 1'b0;
  logic sclk, cs_n, mosi, miso, hv, d15, dcore, irq, rd_done;
  logic [4:0] tcode = 5'h00, vcode;
  logic [9:0] adata = 10'h000;
  logic [7:0] rd_byte, e15 = 8'h00, ecore = 8'h00;
  logic [7:0] exp_q[$];
  brm_mode_t m15, mcore;
  int err_total = 0, n_compared = 0, seed = 72, cyc = 0;

  brm_rail_ctrl dut (.mclk(mclk), .arst_n(arst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(), .standby_exit_pin(stby),
    .gps_supply_rail_1v3(gps), .comms_trim_valid(tvalid), .comms_trim_code(tcode),
    .oc_1v5_detect(oc1), .oc_core_detect(oc2), .adc_valid(avalid), .adc_sel_core(asel),
    .adc_data(adata), .buck_1v5_rail_mode(m15), .buck_1v5_rail_high_v(hv),
    .buck_1v5_rail_discharge(d15), .buck_1v5_rail_fault(), .comms_core_rail_mode(mcore),
    .comms_core_rail_vcode(vcode), .comms_core_rail_discharge(dcore),
    .comms_core_overcurrent_flag(), .regulator_fault_interrupt(irq));
  brm_host_model host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .rd_done(rd_done), .rd_byte(rd_byte));

  ////////////////////////////////////////////////////////////////////
  always #2 mclk = ~mclk;
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a, d});
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer({1'b0, a, 8'h00});
  endtask
  // Read results are matched against notes in issue order
  always @(posedge mclk) if (rd_done) chk("read", rd_byte, exp_q.pop_front());
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk("mode_1v5", m15, BRM_MODE_PWM);
    chk("mode_core", mcore, BRM_MODE_OFF);
    chk("vcode", vcode, 10'h01A);
    chk("dis_core", dcore, 1'b1);
    rd(7'h39, 8'h07);
    rd(7'h3C, 8'h24);
    wr(7'h10, 8'hFF);
    rd(7'h10, 8'h00);
    $display("reset test done");
    for (int c = 4; c < 8; c++) begin
      wr(7'h39, 8'(c));
      wr(7'h3C, 8'(c));
      chk("mode_1v5", m15, 10'(4'h1 << (c - 4)));
      chk("mode_core", mcore, 10'(4'h1 << (c - 4)));
      chk("dis_1v5", d15, 10'(c == 4));
      chk("dis_core", dcore, 10'(c == 4));
      rd(7'h39, 8'(c));
    end
    wr(7'h39, 8'h05);
    chk("mode_1v5", m15, BRM_MODE_PFM);
    $display("state test done");
    // Exit fields set before any exit is used
    wr(7'h39, 8'h2F);
    wr(7'h3C, 8'h37);
    stby = 1'b1;
    repeat (3) @(negedge mclk);
    stby = 1'b0;
    chk("mode_1v5", m15, BRM_MODE_PFM);
    chk("mode_core", mcore, BRM_MODE_APS);
    wr(7'h39, 8'h17);
    stby = 1'b1;
    repeat (3) @(negedge mclk);
    stby = 1'b0;
    chk("mode_1v5", m15, BRM_MODE_PWM);
    // A do-not-copy exit field must leave the register untouched
    rd(7'h39, 8'h17);
    $display("standby test done");
    wr(7'h39, 8'h47);
    chk("high_v", hv, 1'b1);
    wr(7'h39, 8'h07);
    chk("high_v", hv, 1'b0);
    gps = 1'b1;
    repeat (2) @(negedge mclk);
    chk("high_v", hv, 1'b1);
    gps = 1'b0;
    for (int k = 0; k < 6; k++) begin
      tcode = 5'($random(seed));
      tvalid = 1'b1;
      @(negedge mclk);
      tvalid = 1'b0;
      @(negedge mclk);
      chk("vcode", vcode, k < 3 ? 10'h01A : 10'(tcode));
      if (k == 2) wr(7'h3C, 8'h47);
    end
    rd(7'h75, {3'h0, tcode});
    $display("voltage test done");
    for (int k = 0; k < 40; k++) begin
      {oc1, oc2, avalid, asel} = 4'($random(seed));
      adata = 10'($random(seed));
      if (avalid && !asel) e15 = adata[9:2];
      if (avalid && asel) ecore = adata[9:2];
      @(negedge mclk);
      chk("irq", irq, 10'(oc1 | oc2));
    end
    {oc1, oc2, avalid} = 3'h0;
    rd(7'h70, e15);
    rd(7'h72, ecore);
    {oc1, oc2, avalid} = 3'h4;
    rd(7'h74, 8'h01);
    oc1 = 1'b0;
    $display("fault and current test done");
    finish_test();
  end
endmodule

// >>> verilog/brm_rail_ctrl.sv
// Mode, voltage and fault control for the 1.5 V rail and the comms core rail
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - 1.5 V control at 0x39, RW, resets 0x07
// - State bits 2:0: 4 off, 5 PFM, 6 skip, 7 PWM
// - Bits 5:3 copied to state on standby exit
// - Bits 7:6 pick 1.5 V or 1.6 V
// - Core rail mode chosen by register writes
// - Discharge path enabled whenever rail shuts down
// - Rail current results readable by processor
// - Over-current raises rail fault and shared interrupt
// - Wireless setting fixes core rail at 1.25 V
// - 3G setting trims core 0.6-1.375 V serially
// - Core control at 0x3C, resets 0x24, select
// - GPS rail at 1.3 V forces 1.6 V
module brm_rail_ctrl
  import brm_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Host serial register port
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  // System pins
  input  wire logic       standby_exit_pin,
  input  wire logic       gps_supply_rail_1v3,
  // Comms serial trim of the core rail
  input  wire logic       comms_trim_valid,
  input  wire logic [4:0] comms_trim_code,
  // Analog fault and ADC inputs
  input  wire logic       oc_1v5_detect,
  input  wire logic       oc_core_detect,
  input  wire logic       adc_valid,
  input  wire logic       adc_sel_core,
  input  wire logic [9:0] adc_data,
  // 1.5 V rail controls
  output brm_mode_t       buck_1v5_rail_mode,
  output logic            buck_1v5_rail_high_v,
  output logic            buck_1v5_rail_discharge,
  output logic            buck_1v5_rail_fault,
  // Comms core rail controls
  output brm_mode_t       comms_core_rail_mode,
  output logic [4:0]      comms_core_rail_vcode,
  output logic            comms_core_rail_discharge,
  output logic            comms_core_overcurrent_flag,
  // Shared fault
  output logic            regulator_fault_interrupt
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port

  logic [6:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;

  brm_spi_port u_port (
    .mclk    (mclk),
    .rst_n   (rst_n_r),
    .sclk    (spi_sclk),
    .cs_n    (spi_cs_n),
    .mosi    (spi_mosi),
    .miso    (spi_miso),
    .miso_oe (spi_miso_oe),
    .addr    (reg_addr),
    .wr_stb  (reg_wr),
    .wdata   (reg_wdata),
    .rdata   (reg_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] ctl_1v5;
    logic [7:0] ctl_core;
    brm_mode_t  mode_1v5;
    logic       base_hi;
    logic       high_v;
    logic       dis_1v5;
    brm_mode_t  mode_core;
    logic [4:0] trim;
    logic [4:0] vcode;
    logic       dis_core;
    logic       exit_d;
    logic       flt_1v5;
    logic       flt_core;
    logic       irq;
    logic [9:0] cur_1v5;
    logic [9:0] cur_core;
  } brm_state_t;

  localparam brm_state_t BRM_STATE_RST = '{
    ctl_1v5:   BRM_RST_1V5_CTL,
    ctl_core:  BRM_RST_CORE_CTL,
    mode_1v5:  BRM_MODE_PWM,
    base_hi:   1'b0,
    high_v:    1'b0,
    dis_1v5:   1'b0,
    mode_core: BRM_MODE_OFF,
    trim:      BRM_VC_3G_DEF,
    vcode:     BRM_VC_1V25,
    dis_core:  1'b1,
    exit_d:    1'b0,
    flt_1v5:   1'b0,
    flt_core:  1'b0,
    irq:       1'b0,
    cur_1v5:   10'h000,
    cur_core:  10'h000
  };

  brm_state_t s_r;
  brm_state_t s_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Copy the exit field into the state field when it names a state
  function automatic logic [7:0] brm_exit_copy(input logic [7:0] ctl);
    logic [7:0] c;
    c = ctl;
    if (ctl[BRM_EXIT_LSB + BRM_VALID_BIT]) begin
      c[BRM_STATE_LSB +: 3] = ctl[BRM_EXIT_LSB +: 3];
    end
    return c;
  endfunction

  // Reserved codes keep the mode already in force
  function automatic brm_mode_t brm_apply(input logic [7:0] ctl,
                                          input brm_mode_t   cur);
    brm_mode_t m;
    m = cur;
    if (ctl[BRM_STATE_LSB + BRM_VALID_BIT]) begin
      m = brm_decode(ctl[BRM_STATE_LSB +: 3]);
    end
    return m;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Read decode

  always_comb begin
    reg_rdata = 8'h00;
    unique case (reg_addr)
      BRM_ADDR_1V5_CTL:  reg_rdata = s_r.ctl_1v5;
      BRM_ADDR_CORE_CTL: reg_rdata = s_r.ctl_core;
      BRM_ADDR_CUR_1V5H: reg_rdata = s_r.cur_1v5[9:2];
      BRM_ADDR_CUR_1V5L: reg_rdata = {6'h00, s_r.cur_1v5[1:0]};
      BRM_ADDR_CUR_CORH: reg_rdata = s_r.cur_core[9:2];
      BRM_ADDR_CUR_CORL: reg_rdata = {6'h00, s_r.cur_core[1:0]};
      BRM_ADDR_TRIM:     reg_rdata = {3'h0, s_r.trim};
      BRM_ADDR_STATUS: begin
        reg_rdata[BRM_STS_FLT_1V5]  = s_r.flt_1v5;
        reg_rdata[BRM_STS_FLT_CORE] = s_r.flt_core;
        reg_rdata[BRM_STS_HIGH_V]   = s_r.high_v;
        reg_rdata[BRM_STS_GPS]      = gps_supply_rail_1v3;
      end
      default:           reg_rdata = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;

    // Host writes
    if (reg_wr && reg_addr == BRM_ADDR_1V5_CTL) begin
      s_nxt.ctl_1v5 = reg_wdata;
    end
    if (reg_wr && reg_addr == BRM_ADDR_CORE_CTL) begin
      s_nxt.ctl_core = reg_wdata;
    end

    // Standby exit acts after a same-cycle write, so the pin wins
    s_nxt.exit_d = standby_exit_pin;
    if (standby_exit_pin && !s_r.exit_d) begin
      s_nxt.ctl_1v5  = brm_exit_copy(s_nxt.ctl_1v5);
      s_nxt.ctl_core = brm_exit_copy(s_nxt.ctl_core);
    end

    // Modes in force
    s_nxt.mode_1v5  = brm_apply(s_nxt.ctl_1v5, s_r.mode_1v5);
    s_nxt.mode_core = brm_apply(s_nxt.ctl_core, s_r.mode_core);

    // Discharge while off, so a shut rail is never left floating
    s_nxt.dis_1v5  = (s_nxt.mode_1v5 == BRM_MODE_OFF);
    s_nxt.dis_core = (s_nxt.mode_core == BRM_MODE_OFF);

    // 1.5 V rail level; reserved selects keep the last level
    unique case (s_nxt.ctl_1v5[BRM_VSEL_LSB +: 2])
      BRM_VSEL_LOW:  s_nxt.base_hi = 1'b0;
      BRM_VSEL_HIGH: s_nxt.base_hi = 1'b1;
      default:       s_nxt.base_hi = s_r.base_hi;
    endcase
    s_nxt.high_v = s_nxt.base_hi | gps_supply_rail_1v3;

    // Core rail level
    if (comms_trim_valid) begin
      s_nxt.trim = comms_trim_code;
    end
    unique case (s_nxt.ctl_core[BRM_VSEL_LSB +: 2])
      BRM_VSEL_LOW:  s_nxt.vcode = BRM_VC_1V25;
      BRM_VSEL_HIGH: s_nxt.vcode = s_nxt.trim;
      default:       s_nxt.vcode = s_r.vcode;
    endcase

    // Faults follow the comparators; current limiting itself is analog
    s_nxt.flt_1v5  = oc_1v5_detect;
    s_nxt.flt_core = oc_core_detect;
    s_nxt.irq      = oc_1v5_detect | oc_core_detect;

    // ADC current results
    if (adc_valid && !adc_sel_core) begin
      s_nxt.cur_1v5 = adc_data;
    end
    if (adc_valid && adc_sel_core) begin
      s_nxt.cur_core = adc_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= BRM_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign buck_1v5_rail_mode          = s_r.mode_1v5;
  assign buck_1v5_rail_high_v        = s_r.high_v;
  assign buck_1v5_rail_discharge     = s_r.dis_1v5;
  assign buck_1v5_rail_fault         = s_r.flt_1v5;
  assign comms_core_rail_mode        = s_r.mode_core;
  assign comms_core_rail_vcode       = s_r.vcode;
  assign comms_core_rail_discharge   = s_r.dis_core;
  assign comms_core_overcurrent_flag = s_r.flt_core;
  assign regulator_fault_interrupt   = s_r.irq;

endmodule

// >>> verilog/brm_spi_port.sv
// Serial register port: command byte, then data byte in or out
`timescale 1ns/1ps
module brm_spi_port
  import brm_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Serial pins
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe,
  // Register side
  output logic [6:0]      addr,
  output logic            wr_stb,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);

  typedef struct packed {
    logic       sclk_d;
    logic [4:0] cnt;
    logic [15:0] rx;
    logic [7:0] tx;
    logic       miso;
    logic       oe;
    logic       is_wr;
    logic [6:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } brm_spi_t;

  brm_spi_t s_r;
  brm_spi_t s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.wr     = 1'b0;
    s_nxt.sclk_d = sclk;
    s_nxt.oe     = ~cs_n;
    if (cs_n) begin
      s_nxt.cnt  = 5'h00;
      s_nxt.miso = 1'b0;
    end else if (sclk && !s_r.sclk_d && s_r.cnt < BRM_SPI_FRAME_BITS) begin
      s_nxt.rx  = {s_r.rx[14:0], mosi};
      s_nxt.cnt = 5'(s_r.cnt + 5'h01);
      if (s_r.cnt == 5'(BRM_SPI_CMD_BITS - 5'h01)) begin
        s_nxt.is_wr = s_r.rx[6];
        s_nxt.addr  = {s_r.rx[5:0], mosi};
      end
      if (s_r.cnt == 5'(BRM_SPI_FRAME_BITS - 5'h01)) begin
        s_nxt.wr    = s_r.is_wr;
        s_nxt.wdata = {s_r.rx[6:0], mosi};
      end
    end else if (!sclk && s_r.sclk_d && s_r.cnt >= BRM_SPI_CMD_BITS &&
                 s_r.cnt < BRM_SPI_FRAME_BITS) begin
      // Read data is captured once, so a later write cannot tear it
      if (s_r.cnt == BRM_SPI_CMD_BITS) begin
        s_nxt.miso = rdata[7];
        s_nxt.tx   = {rdata[6:0], 1'b0};
      end else begin
        s_nxt.miso = s_r.tx[7];
        s_nxt.tx   = {s_r.tx[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign miso    = s_r.miso;
  assign miso_oe = s_r.oe;
  assign addr    = s_r.addr;
  assign wr_stb  = s_r.wr;
  assign wdata   = s_r.wdata;

endmodule
